//--- core/uirq_consts.svh
`ifndef UIRQ_CONSTS_SVH
`define UIRQ_CONSTS_SVH

// Register offsets on the channel address lines
`define UIRQ_OFF_DATA 3'h0
`define UIRQ_OFF_MASK 3'h1
`define UIRQ_OFF_SRC 3'h2
`define UIRQ_OFF_LINE 3'h5
`define UIRQ_OFF_MODEM 3'h6

// Reset values
`define UIRQ_MASK_RST 8'h00
`define UIRQ_FCTL_RST 8'h00
`define UIRQ_RD_RST 8'h00

// Interrupt mask bit positions
`define UIRQ_MASK_RX 0
`define UIRQ_MASK_TX 1
`define UIRQ_MASK_LS 2
`define UIRQ_MASK_MS 3

// Fifo control bit positions
`define UIRQ_FCTL_EN 0
`define UIRQ_FCTL_DMA 3

// Interrupt source codes, highest priority first
`define UIRQ_SRC_LS 4'h6
`define UIRQ_SRC_RX 4'h4
`define UIRQ_SRC_TX 4'h2
`define UIRQ_SRC_MS 4'h0
`define UIRQ_SRC_NONE 4'h1

// Fifo depth
`define UIRQ_DEPTH 5'h10

`endif

//--- core/uirq_pkg.sv
package uirq_pkg;

  typedef struct packed {
    logic txPend;
    logic txEmptyPrev;
    logic txEnPrev;
    logic irq;
    logic [3:0] srcCode;
  } uirq_chan_st_t;

  typedef struct packed {
    logic rxLatch;
    logic txReqN;
    logic rxReqN;
  } uirq_dma_st_t;

  typedef struct packed {
    logic [7:0] maskA;
    logic [7:0] maskB;
    logic [7:0] fctlA;
    logic [7:0] fctlB;
    logic [7:0] rdData;
  } uirq_top_st_t;

endpackage : uirq_pkg

//--- core/uirq_chan_if.sv
interface uirq_chan_if;
  logic fifoEn;
  logic dmaMode;
  logic [3:0] mask;
  logic [4:0] rxCount;
  logic [4:0] txCount;
  logic [4:0] rxTrig;
  logic [3:0] lineErr;
  logic [3:0] modemDelta;
  logic dataWrite;
  logic srcRead;
  logic irq;
  logic [3:0] srcCode;
  logic txReqN;
  logic rxReqN;

  modport ctrl (
    output fifoEn, dmaMode, mask, rxCount, txCount, rxTrig, lineErr, modemDelta,
    output dataWrite, srcRead,
    input irq, srcCode, txReqN, rxReqN
  );

  modport chan (
    input fifoEn, mask, rxCount, txCount, rxTrig, lineErr, modemDelta,
    input dataWrite, srcRead,
    output irq, srcCode
  );

  modport dma (
    input fifoEn, dmaMode, rxCount, txCount, rxTrig,
    output txReqN, rxReqN
  );
endinterface : uirq_chan_if

//--- core/uirq_chan.sv
`include "uirq_consts.svh"

module uirq_chan (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Channel signals
  uirq_chan_if.chan cif
);

  uirq_pkg::uirq_chan_st_t st_q;
  uirq_pkg::uirq_chan_st_t st_d;
  logic txEmpty;
  logic setTx;
  logic clrTx;
  logic srcLs;
  logic srcRx;
  logic srcTx;
  logic srcMs;

  always_comb begin
    st_d = st_q;
    txEmpty = (cif.txCount == 5'h00);
    // Empty edge, or enabling while already empty
    setTx = (txEmpty && !st_q.txEmptyPrev) ||
            (txEmpty && cif.mask[`UIRQ_MASK_TX] && !st_q.txEnPrev);
    clrTx = cif.dataWrite || (cif.srcRead && (st_q.srcCode == `UIRQ_SRC_TX));
    srcLs = cif.mask[`UIRQ_MASK_LS] && (|cif.lineErr);
    if (cif.fifoEn) begin
      srcRx = cif.mask[`UIRQ_MASK_RX] && (cif.rxCount >= cif.rxTrig);
    end else begin
      srcRx = cif.mask[`UIRQ_MASK_RX] && (cif.rxCount != 5'h00);
    end
    srcTx = cif.mask[`UIRQ_MASK_TX] && st_q.txPend;
    srcMs = cif.mask[`UIRQ_MASK_MS] && (|cif.modemDelta);
    if (setTx) begin
      st_d.txPend = 1'b1;
    end else if (clrTx) begin
      st_d.txPend = 1'b0;
    end
    st_d.txEmptyPrev = txEmpty;
    st_d.txEnPrev = cif.mask[`UIRQ_MASK_TX];
    // Priority encode into the source register
    if (srcLs) begin
      st_d.srcCode = `UIRQ_SRC_LS;
    end else if (srcRx) begin
      st_d.srcCode = `UIRQ_SRC_RX;
    end else if (srcTx) begin
      st_d.srcCode = `UIRQ_SRC_TX;
    end else if (srcMs) begin
      st_d.srcCode = `UIRQ_SRC_MS;
    end else begin
      st_d.srcCode = `UIRQ_SRC_NONE;
    end
    st_d.irq = srcLs || srcRx || srcTx || srcMs;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_q <= '{txPend: 1'b0, txEmptyPrev: 1'b1, txEnPrev: 1'b0, irq: 1'b0,
                srcCode: `UIRQ_SRC_NONE};
    end else begin
      st_q <= st_d;
    end
  end

  assign cif.irq = st_q.irq;
  assign cif.srcCode = st_q.srcCode;

  tx_clear_a: assert property (@(posedge sys_clk) disable iff (srst)
    (cif.dataWrite && !setTx) |=> !st_q.txPend)
    else $error("Transmit interrupt not cleared by data write");

  ls_first_a: assert property (@(posedge sys_clk) disable iff (srst)
    (cif.mask[`UIRQ_MASK_LS] && (|cif.lineErr)) |=> (cif.irq && cif.srcCode == 4'h6))
    else $error("Line status interrupt missing");

  rx_fifo_a: assert property (@(posedge sys_clk) disable iff (srst)
    (cif.fifoEn && cif.mask == 4'h1 && cif.rxCount < cif.rxTrig) |=> !cif.irq)
    else $error("Receive interrupt below trigger level");

endmodule : uirq_chan

//--- core/uirq_dma.sv
`include "uirq_consts.svh"

module uirq_dma (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Channel signals
  uirq_chan_if.dma dif
);

  uirq_pkg::uirq_dma_st_t st_q;
  uirq_pkg::uirq_dma_st_t st_d;
  logic blockMode;
  logic rxEmpty;

  always_comb begin
    st_d = st_q;
    blockMode = dif.fifoEn && dif.dmaMode;
    rxEmpty = (dif.rxCount == 5'h00);
    // Trigger latch, held until the fifo drains; set wins
    if (!rxEmpty && (dif.rxCount >= dif.rxTrig)) begin
      st_d.rxLatch = 1'b1;
    end else if (rxEmpty) begin
      st_d.rxLatch = 1'b0;
    end
    if (blockMode) begin
      st_d.txReqN = !(dif.txCount < `UIRQ_DEPTH);
      st_d.rxReqN = !st_d.rxLatch;
    end else begin
      st_d.txReqN = (dif.txCount != 5'h00);
      st_d.rxReqN = rxEmpty;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_q <= '{rxLatch: 1'b0, txReqN: 1'b0, rxReqN: 1'b1};
    end else begin
      st_q <= st_d;
    end
  end

  assign dif.txReqN = st_q.txReqN;
  assign dif.rxReqN = st_q.rxReqN;

  tx_mode0_a: assert property (@(posedge sys_clk) disable iff (srst)
    (!(dif.fifoEn && dif.dmaMode) && dif.txCount == 5'h00) |=> !dif.txReqN)
    else $error("Mode 0 transmit request not low on empty");

  tx_mode1_a: assert property (@(posedge sys_clk) disable iff (srst)
    (dif.fifoEn && dif.dmaMode && dif.txCount < 5'h10) |=> !dif.txReqN)
    else $error("Mode 1 transmit request not low with free space");

  rx_mode0_a: assert property (@(posedge sys_clk) disable iff (srst)
    !(dif.fifoEn && dif.dmaMode) |-> ##1 (dif.rxReqN == ($past(dif.rxCount) == 5'h00)))
    else $error("Mode 0 receive request wrong");

  rx_mode1_a: assert property (@(posedge sys_clk) disable iff (srst)
    (dif.fifoEn && dif.dmaMode && dif.rxCount != 5'h00 && !dif.rxReqN)
      ##1 (dif.fifoEn && dif.dmaMode && dif.rxCount != 5'h00) |-> !dif.rxReqN)
    else $error("Mode 1 receive request released before empty");

endmodule : uirq_dma

//--- core/uirq_top.sv
`include "uirq_consts.svh"

module uirq_top (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Register access
  input wire logic chanSel,
  input wire logic [2:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] wrData,
  output logic [7:0] rdData,
  // Divisor latch access flags
  input wire logic dlabA,
  input wire logic dlabB,
  // Channel A status
  input wire logic [4:0] rxCountA,
  input wire logic [4:0] txCountA,
  input wire logic [4:0] rxTrigA,
  input wire logic txShiftEmptyA,
  input wire logic [3:0] lineErrA,
  input wire logic fifoDataErrA,
  input wire logic [3:0] modemDeltaA,
  input wire logic [3:0] modemLinesA,
  // Channel B status
  input wire logic [4:0] rxCountB,
  input wire logic [4:0] txCountB,
  input wire logic [4:0] rxTrigB,
  input wire logic txShiftEmptyB,
  input wire logic [3:0] lineErrB,
  input wire logic fifoDataErrB,
  input wire logic [3:0] modemDeltaB,
  input wire logic [3:0] modemLinesB,
  // Fifo control to the rest of the channel
  output logic [7:0] fifoCtrlA,
  output logic [7:0] fifoCtrlB,
  // Interrupt and request pins
  output logic channelAIrq,
  output logic channelBIrq,
  output logic transmitRequestAN,
  output logic transmitRequestBN,
  output logic receiveRequestAN,
  output logic receiveRequestBN
);

  uirq_pkg::uirq_top_st_t st_q;
  uirq_pkg::uirq_top_st_t st_d;
  logic selA;
  logic selB;
  logic [7:0] lineStA;
  logic [7:0] lineStB;
  logic [7:0] srcA;
  logic [7:0] srcB;
  logic [7:0] readA;
  logic [7:0] readB;

  uirq_chan_if ifA ();
  uirq_chan_if ifB ();

  function automatic logic [7:0] uirqReadMux(
    input logic [2:0] addr,
    input logic dlab,
    input logic [7:0] mask,
    input logic [7:0] src,
    input logic [7:0] line,
    input logic [7:0] modem
  );
    logic [7:0] val;
    val = 8'h00;
    case (addr)
      `UIRQ_OFF_MASK: val = dlab ? 8'h00 : mask;
      `UIRQ_OFF_SRC: val = src;
      `UIRQ_OFF_LINE: val = line;
      `UIRQ_OFF_MODEM: val = modem;
      default: val = 8'h00;
    endcase
    return val;
  endfunction : uirqReadMux

  assign selA = !chanSel;
  assign selB = chanSel;

  // Line status assembled from live channel state
  always_comb begin
    lineStA[0] = (rxCountA != 5'h00);
    lineStA[4:1] = lineErrA;
    lineStA[5] = (txCountA == 5'h00);
    lineStA[6] = (txCountA == 5'h00) && txShiftEmptyA;
    lineStA[7] = fifoDataErrA && st_q.fctlA[`UIRQ_FCTL_EN];
    lineStB[0] = (rxCountB != 5'h00);
    lineStB[4:1] = lineErrB;
    lineStB[5] = (txCountB == 5'h00);
    lineStB[6] = (txCountB == 5'h00) && txShiftEmptyB;
    lineStB[7] = fifoDataErrB && st_q.fctlB[`UIRQ_FCTL_EN];
  end

  // Source register: fifo flags on top, priority code below
  assign srcA = {{2{st_q.fctlA[`UIRQ_FCTL_EN]}}, 2'b00, ifA.srcCode};
  assign srcB = {{2{st_q.fctlB[`UIRQ_FCTL_EN]}}, 2'b00, ifB.srcCode};

  assign readA = uirqReadMux(regAddr, dlabA, st_q.maskA, srcA, lineStA,
                             {modemLinesA, modemDeltaA});
  assign readB = uirqReadMux(regAddr, dlabB, st_q.maskB, srcB, lineStB,
                             {modemLinesB, modemDeltaB});

  always_comb begin
    st_d = st_q;
    if (regWrite && selA && regAddr == `UIRQ_OFF_MASK && !dlabA) begin
      st_d.maskA = {4'h0, wrData[3:0]};
    end
    if (regWrite && selB && regAddr == `UIRQ_OFF_MASK && !dlabB) begin
      st_d.maskB = {4'h0, wrData[3:0]};
    end
    // Fifo resets are one-shot commands and are not held
    if (regWrite && selA && regAddr == `UIRQ_OFF_SRC) begin
      st_d.fctlA = {wrData[7:6], 2'b00, wrData[3], 2'b00, wrData[0]};
    end
    if (regWrite && selB && regAddr == `UIRQ_OFF_SRC) begin
      st_d.fctlB = {wrData[7:6], 2'b00, wrData[3], 2'b00, wrData[0]};
    end
    if (regRead) begin
      st_d.rdData = selA ? readA : readB;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_q <= '{maskA: `UIRQ_MASK_RST, maskB: `UIRQ_MASK_RST, fctlA: `UIRQ_FCTL_RST,
                fctlB: `UIRQ_FCTL_RST, rdData: `UIRQ_RD_RST};
    end else begin
      st_q <= st_d;
    end
  end

  // Channel A hookup
  assign ifA.fifoEn = st_q.fctlA[`UIRQ_FCTL_EN];
  assign ifA.dmaMode = st_q.fctlA[`UIRQ_FCTL_DMA];
  assign ifA.mask = st_q.maskA[3:0];
  assign ifA.rxCount = rxCountA;
  assign ifA.txCount = txCountA;
  assign ifA.rxTrig = rxTrigA;
  assign ifA.lineErr = lineErrA;
  assign ifA.modemDelta = modemDeltaA;
  assign ifA.dataWrite = regWrite && selA && regAddr == `UIRQ_OFF_DATA && !dlabA;
  assign ifA.srcRead = regRead && selA && regAddr == `UIRQ_OFF_SRC;

  // Channel B hookup
  assign ifB.fifoEn = st_q.fctlB[`UIRQ_FCTL_EN];
  assign ifB.dmaMode = st_q.fctlB[`UIRQ_FCTL_DMA];
  assign ifB.mask = st_q.maskB[3:0];
  assign ifB.rxCount = rxCountB;
  assign ifB.txCount = txCountB;
  assign ifB.rxTrig = rxTrigB;
  assign ifB.lineErr = lineErrB;
  assign ifB.modemDelta = modemDeltaB;
  assign ifB.dataWrite = regWrite && selB && regAddr == `UIRQ_OFF_DATA && !dlabB;
  assign ifB.srcRead = regRead && selB && regAddr == `UIRQ_OFF_SRC;

  uirq_chan chanA (
    .sys_clk(sys_clk),
    .srst(srst),
    .cif(ifA.chan)
  );

  uirq_chan chanB (
    .sys_clk(sys_clk),
    .srst(srst),
    .cif(ifB.chan)
  );

  uirq_dma dmaA (
    .sys_clk(sys_clk),
    .srst(srst),
    .dif(ifA.dma)
  );

  uirq_dma dmaB (
    .sys_clk(sys_clk),
    .srst(srst),
    .dif(ifB.dma)
  );

  // Pins, each channel on its own
  assign channelAIrq = ifA.irq;
  assign channelBIrq = ifB.irq;
  assign transmitRequestAN = ifA.txReqN;
  assign transmitRequestBN = ifB.txReqN;
  assign receiveRequestAN = ifA.rxReqN;
  assign receiveRequestBN = ifB.rxReqN;
  assign fifoCtrlA = st_q.fctlA;
  assign fifoCtrlB = st_q.fctlB;
  assign rdData = st_q.rdData;

  ier_reset_a: assert property (@(posedge sys_clk) disable iff (srst)
    $fell(srst) |-> (st_q.maskA == 8'h00 && st_q.maskB == 8'h00))
    else $error("Mask register not cleared by reset");

  ier_upper_a: assert property (@(posedge sys_clk) disable iff (srst)
    (st_q.maskA[7:4] == 4'h0) && (st_q.maskB[7:4] == 4'h0))
    else $error("Unused mask bits not zero");

  modem_irq_a: assert property (@(posedge sys_clk) disable iff (srst)
    (st_q.maskA[3] && (|modemDeltaA)) |=> channelAIrq)
    else $error("Modem interrupt missing on channel A");

  tx_irq_a: assert property (@(posedge sys_clk) disable iff (srst)
    (st_q.maskA == 8'h02 && txCountA == 5'h00 && $past(txCountA) != 5'h00)
      ##1 (st_q.maskA == 8'h02) |=> (channelAIrq && ifA.srcCode == 4'h2))
    else $error("Transmit empty interrupt missing on channel A");

  rx_level_a: assert property (@(posedge sys_clk) disable iff (srst)
    (!st_q.fctlA[0] && st_q.maskA == 8'h01 && rxCountA != 5'h00)
      |=> (channelAIrq && ifA.srcCode == 4'h4))
    else $error("Receive interrupt missing on channel A");

  polled_quiet_a: assert property (@(posedge sys_clk) disable iff (srst)
    (st_q.maskA[3:0] == 4'h0) |=> !channelAIrq)
    else $error("Interrupt raised with all sources masked");

  lsr_read_a: assert property (@(posedge sys_clk) disable iff (srst)
    (regRead && selA && regAddr == 3'h5)
      |=> (rdData[5] == $past(txCountA == 5'h00) && rdData[0] == $past(rxCountA != 5'h00)))
    else $error("Line status read mismatch");

  lsr_err_a: assert property (@(posedge sys_clk) disable iff (srst)
    (regRead && selA && regAddr == 3'h5) |=> (rdData[4:1] == $past(lineErrA)))
    else $error("Line status error bits mismatch");

endmodule : uirq_top

//--- tb/uirq_host_model.sv
module uirq_host_model (
  // Clock
  input wire logic sys_clk,
  // Register access
  output logic chanSel,
  output logic [2:0] regAddr,
  output logic regWrite,
  output logic regRead,
  output logic [7:0] wrData,
  input wire logic [7:0] rdData,
  // Divisor latch flags
  output logic dlabA,
  output logic dlabB
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    chanSel = 1'b0;
    regAddr = 3'h0;
    regWrite = 1'b0;
    regRead = 1'b0;
    wrData = 8'h00;
    dlabA = 1'b0;
    dlabB = 1'b0;
  end

  // One-cycle write strobe, then time for the effect to land
  task automatic wr(input logic ch, input logic [2:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    chanSel = ch;
    regAddr = a;
    wrData = d;
    regWrite = 1'b1;
    @(negedge sys_clk);
    regWrite = 1'b0;
    repeat (2) @(negedge sys_clk);
  endtask : wr

  // Polls status by plain reads; data is registered one edge later
  task automatic rd(input logic ch, input logic [2:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    chanSel = ch;
    regAddr = a;
    regRead = 1'b1;
    @(negedge sys_clk);
    regRead = 1'b0;
    repeat (2) @(negedge sys_clk);
    d = rdData;
  endtask : rd

  task automatic setDlab(input logic ch, input logic v);
    @(negedge sys_clk);
    if (ch) dlabB = v;
    else dlabA = v;
  endtask : setDlab
endmodule : uirq_host_model

//--- tb/tb_uirq_top.sv
`include "uirq_consts.svh"

module tb_uirq_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic chanSel;
  logic [2:0] regAddr;
  logic regWrite;
  logic regRead;
  logic [7:0] wrData;
  logic [7:0] rdData;
  logic dlabA;
  logic dlabB;
  logic [4:0] rxCnt [2] = '{5'h00, 5'h00};
  logic [4:0] txCnt [2] = '{5'h00, 5'h00};
  logic [4:0] rxTrg [2] = '{5'h04, 5'h04};
  logic shEmp [2] = '{1'b0, 1'b0};
  logic [3:0] lnErr [2] = '{4'h0, 4'h0};
  logic fErr [2] = '{1'b0, 1'b0};
  logic [3:0] mDelta [2] = '{4'h0, 4'h0};
  logic [3:0] mLines [2] = '{4'h0, 4'h0};
  logic [15:0] fctlV;
  logic [1:0] irqV;
  logic [1:0] txRqV;
  logic [1:0] rxRqV;
  logic [7:0] v;
  int errorCnt = 0;
  int numChecks = 0;

  always #12.5 sys_clk = ~sys_clk;

  uirq_host_model u_host (.sys_clk(sys_clk), .chanSel(chanSel), .regAddr(regAddr),
    .regWrite(regWrite), .regRead(regRead), .wrData(wrData), .rdData(rdData),
    .dlabA(dlabA), .dlabB(dlabB));

  uirq_top u_dut (.sys_clk(sys_clk), .srst(srst), .chanSel(chanSel), .regAddr(regAddr),
    .regWrite(regWrite), .regRead(regRead), .wrData(wrData), .rdData(rdData),
    .dlabA(dlabA), .dlabB(dlabB),
    .rxCountA(rxCnt[0]), .txCountA(txCnt[0]), .rxTrigA(rxTrg[0]), .txShiftEmptyA(shEmp[0]),
    .lineErrA(lnErr[0]), .fifoDataErrA(fErr[0]), .modemDeltaA(mDelta[0]),
    .modemLinesA(mLines[0]),
    .rxCountB(rxCnt[1]), .txCountB(txCnt[1]), .rxTrigB(rxTrg[1]), .txShiftEmptyB(shEmp[1]),
    .lineErrB(lnErr[1]), .fifoDataErrB(fErr[1]), .modemDeltaB(mDelta[1]),
    .modemLinesB(mLines[1]),
    .fifoCtrlA(fctlV[7:0]), .fifoCtrlB(fctlV[15:8]),
    .channelAIrq(irqV[0]), .channelBIrq(irqV[1]),
    .transmitRequestAN(txRqV[0]), .transmitRequestBN(txRqV[1]),
    .receiveRequestAN(rxRqV[0]), .receiveRequestBN(rxRqV[1]));

  task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    numChecks++;
    if (seen !== exp) begin
      errorCnt++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk

  task automatic settle();
    repeat (3) @(negedge sys_clk);
  endtask : settle

  task automatic endTest(input string n);
    $display("test %s finished", n);
  endtask : endTest

  task automatic testDone();
    $display("checks %0d mismatches %0d", numChecks, errorCnt);
    if (errorCnt == 0 && numChecks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : testDone

  initial begin
    repeat (20000) @(posedge sys_clk);
    errorCnt++;
    testDone();
  end

  initial begin
    logic ch;
    logic oth;
    repeat (8) @(negedge sys_clk);
    srst = 1'b0;
    for (int c = 0; c < 2; c++) begin
      ch = c[0];
      oth = ~ch;
      u_host.rd(ch, `UIRQ_OFF_MASK, v); chk("mask reset", v, 8'h00);
      u_host.rd(ch, `UIRQ_OFF_SRC, v); chk("source reset", v, 8'h01);
      chk("tx req reset", {7'h00, txRqV[ch]}, 8'h00);
      chk("rx req reset", {7'h00, rxRqV[ch]}, 8'h01);
      u_host.wr(ch, `UIRQ_OFF_MASK, 8'hFF);
      u_host.rd(ch, `UIRQ_OFF_MASK, v); chk("mask unused", v, 8'h0F);
      u_host.wr(ch, `UIRQ_OFF_MASK, 8'h00);
      u_host.setDlab(ch, 1'b1);
      u_host.wr(ch, `UIRQ_OFF_MASK, 8'h0F);
      u_host.setDlab(ch, 1'b0);
      u_host.rd(ch, `UIRQ_OFF_MASK, v); chk("mask dlab", v, 8'h00);
      u_host.rd(ch, 3'h7, v); chk("unmapped", v, 8'h00);
      endTest("reset");
      lnErr[ch] = 4'h2;
      u_host.wr(ch, `UIRQ_OFF_MASK, 8'h04);
      chk("line irq", {7'h00, irqV[ch]}, 8'h01);
      chk("other irq", {7'h00, irqV[oth]}, 8'h00);
      u_host.rd(ch, `UIRQ_OFF_SRC, v); chk("line code", v, 8'h06);
      lnErr[ch] = 4'h0;
      settle(); chk("line gone", {7'h00, irqV[ch]}, 8'h00);
      mDelta[ch] = 4'h1;
      u_host.wr(ch, `UIRQ_OFF_MASK, 8'h08);
      chk("modem irq", {7'h00, irqV[ch]}, 8'h01);
      u_host.rd(ch, `UIRQ_OFF_SRC, v); chk("modem code", v, 8'h00);
      mDelta[ch] = 4'h0;
      rxCnt[ch] = 5'h01;
      u_host.wr(ch, `UIRQ_OFF_MASK, 8'h01);
      chk("rx irq", {7'h00, irqV[ch]}, 8'h01);
      u_host.rd(ch, `UIRQ_OFF_SRC, v); chk("rx code", v, 8'h04);
      rxCnt[ch] = 5'h00;
      settle(); chk("rx gone", {7'h00, irqV[ch]}, 8'h00);
      u_host.wr(ch, `UIRQ_OFF_MASK, 8'h02);
      u_host.rd(ch, `UIRQ_OFF_SRC, v); chk("tx code", v, 8'h02);
      settle(); chk("tx read clr", {7'h00, irqV[ch]}, 8'h00);
      txCnt[ch] = 5'h03;
      settle();
      txCnt[ch] = 5'h00;
      settle(); chk("tx drained", {7'h00, irqV[ch]}, 8'h01);
      u_host.wr(ch, `UIRQ_OFF_DATA, 8'h55);
      chk("tx write clr", {7'h00, irqV[ch]}, 8'h00);
      endTest("interrupts");
      u_host.wr(ch, `UIRQ_OFF_SRC, 8'h01);
      u_host.wr(ch, `UIRQ_OFF_MASK, 8'h01);
      rxCnt[ch] = 5'h03;
      settle(); chk("below trig", {7'h00, irqV[ch]}, 8'h00);
      rxCnt[ch] = 5'h04;
      settle(); chk("at trig", {7'h00, irqV[ch]}, 8'h01);
      u_host.rd(ch, `UIRQ_OFF_SRC, v); chk("trig code", v, 8'hC4);
      rxCnt[ch] = 5'h03;
      settle(); chk("trig gone", {7'h00, irqV[ch]}, 8'h00);
      u_host.rd(ch, `UIRQ_OFF_SRC, v); chk("trig code gone", v, 8'hC1);
      u_host.wr(ch, `UIRQ_OFF_MASK, 8'h00);
      lnErr[ch] = 4'hA;
      mDelta[ch] = 4'h1;
      fErr[ch] = 1'b1;
      rxCnt[ch] = 5'h05;
      settle(); chk("polled irq", {7'h00, irqV[ch]}, 8'h00);
      u_host.rd(ch, `UIRQ_OFF_LINE, v); chk("line busy", v, 8'hB5);
      shEmp[ch] = 1'b1;
      rxCnt[ch] = 5'h00;
      u_host.rd(ch, `UIRQ_OFF_LINE, v); chk("line idle", v, 8'hF4);
      lnErr[ch] = 4'h0;
      mDelta[ch] = 4'h0;
      fErr[ch] = 1'b0;
      endTest("fifo");
      txCnt[ch] = 5'h01;
      settle(); chk("m0 tx full", {7'h00, txRqV[ch]}, 8'h01);
      txCnt[ch] = 5'h00;
      settle(); chk("m0 tx empty", {7'h00, txRqV[ch]}, 8'h00);
      rxCnt[ch] = 5'h01;
      settle(); chk("m0 rx char", {7'h00, rxRqV[ch]}, 8'h00);
      rxCnt[ch] = 5'h00;
      settle(); chk("m0 rx empty", {7'h00, rxRqV[ch]}, 8'h01);
      u_host.wr(ch, `UIRQ_OFF_SRC, 8'h09);
      chk("fifo ctrl", ch ? fctlV[15:8] : fctlV[7:0], 8'h09);
      txCnt[ch] = 5'h0F;
      settle(); chk("m1 tx slot", {7'h00, txRqV[ch]}, 8'h00);
      txCnt[ch] = 5'h10;
      settle(); chk("m1 tx full", {7'h00, txRqV[ch]}, 8'h01);
      rxCnt[ch] = 5'h03;
      settle(); chk("m1 rx low", {7'h00, rxRqV[ch]}, 8'h01);
      rxCnt[ch] = 5'h04;
      settle(); chk("m1 rx trig", {7'h00, rxRqV[ch]}, 8'h00);
      rxCnt[ch] = 5'h02;
      settle(); chk("m1 rx hold", {7'h00, rxRqV[ch]}, 8'h00);
      rxCnt[ch] = 5'h00;
      settle(); chk("m1 rx empty", {7'h00, rxRqV[ch]}, 8'h01);
      txCnt[ch] = 5'h05;
      u_host.wr(ch, `UIRQ_OFF_MASK, 8'h02);
      u_host.rd(ch, `UIRQ_OFF_SRC, v);
      settle(); chk("m1 tx busy", {7'h00, irqV[ch]}, 8'h00);
      txCnt[ch] = 5'h00;
      settle(); chk("m1 tx int", {7'h00, irqV[ch]}, 8'h01);
      u_host.wr(ch, `UIRQ_OFF_MASK, 8'h00);
      u_host.wr(ch, `UIRQ_OFF_SRC, 8'h00);
      shEmp[ch] = 1'b0;
      endTest("dma");
    end
    testDone();
  end
endmodule : tb_uirq_top
